// [design/sstc_core.sv]
// Eight-bit full-duplex serial shift core, master or slave, with AXI regs.
`timescale 1ns/1ps
`include "sstc_params.svh"
module sstc_core import sstc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SSTC_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SSTC_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire sstc_pins_t pin_i,
  output sstc_pins_t pin_o,
  output sstc_pins_t pin_oe,
  output logic irq
);
  localparam sstc_state_t ST_RST = '{
    fsm: SSTC_IDLE, cr1: `SSTC_CR1_RST, cr2: `SSTC_CR2_RST,
    br: `SSTC_BR_RST, ien: `SSTC_IEN_RST, ss_o: 1'b1, default: '0};

  sstc_state_t s;
  sstc_state_t n;
  sstc_pins_t pq;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [7:0] sr;
  logic [4:0] e;
  logic [10:0] half;
  logic tick;
  logic edge_now;
  logic bit_in;
  logic fault_now;
  logic mst;
  logic en;
  logic clock_idle_level;
  logic clock_sample_phase;
  logic lsbf;
  logic ss_drive;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bit presented on the data line for the chosen bit order.
  function automatic logic outbit(input logic [7:0] v, input logic lsbf_i);
    return lsbf_i ? v[0] : v[7];
  endfunction

  // Shift one captured bit into the register for the chosen bit order.
  function automatic logic [7:0] shin(input logic [7:0] v, input logic b,
                                      input logic lsbf_i);
    return lsbf_i ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Bus clocks per half serial clock period.
  function automatic logic [10:0] half_of(input logic [7:0] b);
    return 11'((11'(b[6:4]) + 11'h001) << b[2:0]);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  sstc_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_i(pin_i),
    .pin_q(pq)
  );

  // Control fields used throughout.
  assign mst = s.cr1[`SSTC_CR1_MASTER_SELECT];
  assign en = s.cr1[`SSTC_CR1_MODE];
  assign clock_idle_level = s.cr1[`SSTC_CR1_CLOCK_IDLE_LEVEL];
  assign clock_sample_phase = s.cr1[`SSTC_CR1_CLOCK_SAMPLE_PHASE];
  assign lsbf = s.cr1[`SSTC_CR1_LSBF];
  assign ss_drive = s.cr1[`SSTC_CR1_SELECT_OUTPUT_ENABLE] & s.cr2[`SSTC_CR2_FDE];
  assign half = half_of(s.br);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Order matters: reads clear flags first, the engine may then set them
  // again so a set wins, and bus writes come last so a data byte written
  // in the cycle the engine empties the buffer is kept, not lost.
  always_comb begin
    n = s;
    ev = 3'h0;
    clr = 3'h0;
    tick = 1'b0;
    edge_now = 1'b0;
    bit_in = 1'b0;
    fault_now = 1'b0;
    e = 5'(s.edges + 5'h01);
    sr = 8'h00;
    sr[`SSTC_SR_DONE] = s.done;
    sr[`SSTC_SR_TXE] = ~s.tx_full;
    sr[`SSTC_SR_FLT] = s.fault;

    // Read channel; status read then data read clears the done flag.
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp_err = 1'b0;
      n.rdat = 8'h00;
      case (araddr[5:2])
        `SSTC_IDX_CR1: n.rdat = s.cr1;
        `SSTC_IDX_CR2: n.rdat = s.cr2;
        `SSTC_IDX_BR: n.rdat = s.br;
        `SSTC_IDX_SR: begin
          n.rdat = sr;
          n.sr_seen = s.done;
        end
        `SSTC_IDX_DR: begin
          n.rdat = s.rx_data;
          if (s.sr_seen) begin
            n.done = 1'b0;
            n.sr_seen = 1'b0;
          end
        end
        `SSTC_IDX_IST: n.rdat = {5'h00, s.ist};
        `SSTC_IDX_IEN: n.rdat = {5'h00, s.ien};
        `SSTC_IDX_RSV4, `SSTC_IDX_RSV6, `SSTC_IDX_RSV7,
        `SSTC_IDX_ICLR: n.rdat = 8'h00;
        default: n.rresp_err = 1'b1;
      endcase
    end

    // Transfer engine.
    if (!en) begin
      n.fsm = SSTC_IDLE;
      n.edges = 5'h00;
      n.cnt = 11'h000;
      n.sck_o = clock_idle_level;
      n.ss_o = 1'b1;
    end else if (mst) begin
      // A low select while we do not drive it means a rival master.
      fault_now = s.cr2[`SSTC_CR2_FDE] & ~s.cr1[`SSTC_CR1_SELECT_OUTPUT_ENABLE] &
                  ~pq.ss_n;
      if (fault_now) begin
        n.fault = 1'b1;
        ev[`SSTC_EV_FLT] = ~s.fault;
        n.cr1[`SSTC_CR1_MASTER_SELECT] = 1'b0;
        n.fsm = SSTC_IDLE;
        n.edges = 5'h00;
        n.sck_o = clock_idle_level;
        n.ss_o = 1'b1;
      end else begin
        tick = (s.fsm != SSTC_IDLE) && (s.cnt == 11'h000);
        if (s.fsm != SSTC_IDLE) begin
          n.cnt = tick ? 11'(half - 11'h001) : 11'(s.cnt - 11'h001);
        end
        unique case (s.fsm)
          SSTC_IDLE: begin
            n.sck_o = clock_idle_level;
            n.ss_o = 1'b1;
            if (s.tx_full) begin
              n.sh = s.tx_buf;
              n.tx_full = 1'b0;
              ev[`SSTC_EV_TXE] = 1'b1;
              n.edges = 5'h00;
              n.ss_o = 1'b0;
              n.cnt = 11'(half - 11'h001);
              n.fsm = SSTC_LEAD;
            end
          end
          SSTC_LEAD, SSTC_SHIFT: begin
            // First edge comes one half period after the lead-in.
            if (tick) begin
              edge_now = 1'b1;
              bit_in = pq.miso;
              n.fsm = (e == `SSTC_EDGES) ? SSTC_TRAIL : SSTC_SHIFT;
            end
          end
          SSTC_TRAIL: begin
            if (tick) begin
              // Phase one latches its last bit on the final edge, so the
              // closing shift waits until here to keep the data line still.
              if (clock_sample_phase) begin
                n.sh = shin(s.sh, s.rx_bit, lsbf);
              end
              n.rx_data = n.sh;
              n.done = 1'b1;
              ev[`SSTC_EV_DONE] = 1'b1;
              n.edges = 5'h00;
              // Select must bounce in phase zero, so no chaining there while the core drives it.
              if (s.tx_full && (clock_sample_phase || !ss_drive)) begin
                n.sh = s.tx_buf;
                n.tx_full = 1'b0;
                ev[`SSTC_EV_TXE] = 1'b1;
                n.fsm = SSTC_SHIFT;
              end else begin
                n.ss_o = 1'b1;
                n.fsm = SSTC_GAP;
              end
            end
          end
          SSTC_GAP: begin
            if (tick) begin
              n.fsm = SSTC_IDLE;
            end
          end
          default: n.fsm = SSTC_IDLE;
        endcase
      end
    end else begin
      // Slave: clock edges are found by comparing filtered samples.
      n.fsm = SSTC_IDLE;
      n.sck_prev = pq.sck;
      if (pq.ss_n) begin
        n.edges = 5'h00;
      end else if (pq.sck != s.sck_prev) begin
        edge_now = 1'b1;
        bit_in = pq.mosi;
      end
      if (s.tx_full && s.edges == 5'h00 && !edge_now) begin
        n.sh = s.tx_buf;
        n.tx_full = 1'b0;
        ev[`SSTC_EV_TXE] = 1'b1;
      end
    end

    // One serial clock edge: latch or shift by phase and edge number.
    if (edge_now) begin
      n.edges = e;
      if (mst) begin
        n.sck_o = ~s.sck_o;
      end
      if (clock_sample_phase ? ~e[0] : e[0]) begin
        n.rx_bit = bit_in;
        if (clock_sample_phase && e == `SSTC_EDGES && !mst) begin
          n.sh = shin(s.sh, bit_in, lsbf);
        end
      end else if (!clock_sample_phase || e != 5'h01) begin
        n.sh = shin(s.sh, s.rx_bit, lsbf);
      end
      if (!mst && e == `SSTC_EDGES) begin
        n.rx_data = n.sh;
        n.done = 1'b1;
        ev[`SSTC_EV_DONE] = 1'b1;
        n.edges = 5'h00;
      end
    end

    // Write channel; address and data are taken in either order.
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (awvalid && !s.aw_ok && !s.bvalid) begin
      n.aw_ok = 1'b1;
      n.awidx = awaddr[5:2];
    end
    if (wvalid && !s.w_ok && !s.bvalid) begin
      n.w_ok = 1'b1;
      n.wdat = wdata[7:0];
      n.wen = wstrb[0];
    end
    if (s.aw_ok && s.w_ok) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp_err = 1'b0;
      case (s.awidx)
        `SSTC_IDX_CR1: begin
          if (s.wen) begin
            n.cr1 = s.wdat;
            n.fault = fault_now;
          end
        end
        `SSTC_IDX_CR2: if (s.wen) n.cr2 = s.wdat & `SSTC_CR2_MASK;
        `SSTC_IDX_BR: if (s.wen) n.br = s.wdat & `SSTC_BR_MASK;
        `SSTC_IDX_DR: begin
          if (s.wen) begin
            n.tx_buf = s.wdat;
            n.tx_full = 1'b1;
          end
        end
        `SSTC_IDX_ICLR: if (s.wen) clr = s.wdat[2:0];
        `SSTC_IDX_IEN: if (s.wen) n.ien = s.wdat[2:0];
        `SSTC_IDX_SR, `SSTC_IDX_RSV4, `SSTC_IDX_RSV6,
        `SSTC_IDX_RSV7, `SSTC_IDX_IST: n.bresp_err = 1'b0;
        default: n.bresp_err = 1'b1;
      endcase
    end

    // Sticky events; a new event beats a clear in the same cycle.
    n.ist = (s.ist & ~clr) | ev;
    n.dout = outbit(n.sh, lsbf);
  end

  // All state is held still while the clock enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The slave data line is released whenever select is high.
  assign pin_o = '{sck: s.sck_o, mosi: s.dout, miso: s.dout, ss_n: s.ss_o};
  assign pin_oe = '{sck: mst & en, mosi: mst & en,
                    miso: ~mst & en & ~pq.ss_n,
                    ss_n: mst & en & ss_drive};
  assign irq = |(s.ist & s.ien & {s.cr1[`SSTC_CR1_IRQE],
                 s.cr1[`SSTC_CR1_TXIE], s.cr1[`SSTC_CR1_IRQE]});
  assign awready = ~s.aw_ok & ~s.bvalid;
  assign wready = ~s.w_ok & ~s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp_err ? `SSTC_RESP_ERR : `SSTC_RESP_OK;
  assign arready = ~s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = {24'h000000, s.rdat};
  assign rresp = s.rresp_err ? `SSTC_RESP_ERR : `SSTC_RESP_OK;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_IDLE_CLK: assert property (
    (s.fsm == SSTC_IDLE && mst && en && ce) |=> s.sck_o == $past(clock_idle_level))
    else $error("Idle master clock not at polarity level");
  AST_SS_LOW: assert property (
    (s.fsm inside {SSTC_LEAD, SSTC_SHIFT, SSTC_TRAIL} && mst && en)
    |-> !s.ss_o)
    else $error("Select not low during a master transfer");
  AST_EDGE_MAX: assert property (
    s.edges <= `SSTC_EDGES)
    else $error("Edge count passed sixteen");
  AST_GAP_SS: assert property (
    (s.fsm == SSTC_GAP && mst && en) |-> s.ss_o)
    else $error("Select low during the idle gap");
  AST_RX_COPY: assert property (
    (s.fsm == SSTC_TRAIL && tick && ce && !fault_now)
    |=> s.rx_data == $past(clock_sample_phase ? shin(s.sh, s.rx_bit, lsbf) : s.sh))
    else $error("Received byte not copied at transfer end");
  AST_DONE_SET: assert property (
    (s.fsm == SSTC_TRAIL && tick && ce && !fault_now) |=> s.done)
    else $error("Done flag not set after last edge");
  AST_B2B: assert property (
    (s.fsm == SSTC_TRAIL && tick && ce && !fault_now && s.tx_full && clock_sample_phase)
    |=> s.fsm == SSTC_SHIFT && !s.ss_o)
    else $error("Waiting byte not chained at once");
  AST_SLV_QUIET: assert property (
    (!mst && pq.ss_n) |-> !pin_oe.miso && !pin_oe.mosi)
    else $error("Unselected slave drives the bus");
  AST_START: assert property (
    (s.fsm == SSTC_IDLE && mst && en && s.tx_full && ce && !fault_now)
    |=> s.fsm == SSTC_LEAD && !s.tx_full)
    else $error("Data write did not start a transfer");
  AST_HOLD_SCK: assert property (
    (s.fsm == SSTC_SHIFT && s.cnt != 11'h000 && mst && en && ce &&
     !fault_now) |=> $stable(s.sck_o))
    else $error("Serial clock moved inside a half period");

  COV_MASTER: cover property (s.fsm == SSTC_TRAIL && tick);
  COV_SLAVE: cover property (!mst && edge_now && e == `SSTC_EDGES);
  COV_CHAIN: cover property (s.fsm == SSTC_TRAIL ##1 s.fsm == SSTC_SHIFT);
  COV_FAULT: cover property (fault_now);
endmodule

// [design/sstc_params.svh]
// Register map, field positions, reset values and counts of the serial core.
`ifndef SSTC_PARAMS_SVH
`define SSTC_PARAMS_SVH
// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define SSTC_AW 6
`define SSTC_IDX_CR1 4'h0
`define SSTC_IDX_CR2 4'h1
`define SSTC_IDX_BR 4'h2
`define SSTC_IDX_SR 4'h3
`define SSTC_IDX_RSV4 4'h4
`define SSTC_IDX_DR 4'h5
`define SSTC_IDX_RSV6 4'h6
`define SSTC_IDX_RSV7 4'h7
`define SSTC_IDX_IST 4'h8
`define SSTC_IDX_ICLR 4'h9
`define SSTC_IDX_IEN 4'ha
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define SSTC_CR1_IRQE 7
`define SSTC_CR1_MODE 6
`define SSTC_CR1_TXIE 5
`define SSTC_CR1_MASTER_SELECT 4
`define SSTC_CR1_CLOCK_IDLE_LEVEL 3
`define SSTC_CR1_CLOCK_SAMPLE_PHASE 2
`define SSTC_CR1_SELECT_OUTPUT_ENABLE 1
`define SSTC_CR1_LSBF 0
`define SSTC_CR2_FDE 4
`define SSTC_CR2_MASK 8'h13
`define SSTC_BR_MASK 8'h77
`define SSTC_SR_DONE 7
`define SSTC_SR_TXE 5
`define SSTC_SR_FLT 4
`define SSTC_EV_DONE 0
`define SSTC_EV_TXE 1
`define SSTC_EV_FLT 2
// ----------------------------------------------------------------------
// Reset values, counts and bus answers.
// ----------------------------------------------------------------------
`define SSTC_CR1_RST 8'h00
`define SSTC_CR2_RST 8'h00
`define SSTC_BR_RST 8'h00
`define SSTC_IEN_RST 3'h0
`define SSTC_PIN_RST 4'h1
`define SSTC_EDGES 5'h10
`define SSTC_RESP_OK 2'h0
`define SSTC_RESP_ERR 2'h2
`endif

// [design/sstc_pin_sync.sv]
// Three-stage synchroniser with agreement filter for the serial pins.
`timescale 1ns/1ps
`include "sstc_params.svh"
module sstc_pin_sync import sstc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire sstc_pins_t pin_i,
  output sstc_pins_t pin_q
);
  sstc_sync_t s;
  sstc_sync_t n;

  // The output only follows once stages two and three agree.
  always_comb begin
    n = s;
    n.s1 = pin_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.q = sstc_pins_t'((s.s3 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3)));
  end

  // Pins idle with select high so nothing is selected out of reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= sstc_sync_t'({4{`SSTC_PIN_RST}});
    end else if (ce) begin
      s <= n;
    end
  end

  assign pin_q = s.q;
endmodule

// [design/sstc_pkg.sv]
// Types shared by the serial core and its pin synchroniser.
package sstc_pkg;
  typedef enum logic [2:0] {
    SSTC_IDLE = 3'h0,
    SSTC_LEAD = 3'h1,
    SSTC_SHIFT = 3'h3,
    SSTC_TRAIL = 3'h2,
    SSTC_GAP = 3'h6
  } sstc_fsm_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } sstc_pins_t;
  typedef struct packed {
    sstc_pins_t s1;
    sstc_pins_t s2;
    sstc_pins_t s3;
    sstc_pins_t q;
  } sstc_sync_t;
  typedef struct packed {
    sstc_fsm_t fsm;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] br;
    logic [7:0] tx_buf;
    logic tx_full;
    logic [7:0] rx_data;
    logic [7:0] sh;
    logic rx_bit;
    logic [4:0] edges;
    logic [10:0] cnt;
    logic sck_o;
    logic dout;
    logic ss_o;
    logic done;
    logic fault;
    logic sr_seen;
    logic [2:0] ist;
    logic [2:0] ien;
    logic aw_ok;
    logic [3:0] awidx;
    logic w_ok;
    logic [7:0] wdat;
    logic wen;
    logic bvalid;
    logic bresp_err;
    logic rvalid;
    logic rresp_err;
    logic [7:0] rdat;
    logic sck_prev;
  } sstc_state_t;
endpackage

// [dv/sstc_slave_model.sv]
// Behavioural serial peripheral that answers the core in master mode.
`timescale 1ns/1ps
module sstc_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic clock_sample_phase,
  input wire logic lsbf,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int k = 0;
  logic [7:0] acc = 8'h00;
  // Bit i of a frame sits at this index of the byte.
  function automatic int pos(input int i);
    return lsbf ? i : 7 - i;
  endfunction
  // The line has no pull, so it starts at an arbitrary level.
  initial miso = 1'h1;
  // Selection restarts the count; phase zero shows the first bit at once.
  always @(negedge ss_n) begin
    k = 0;
    if (!clock_sample_phase) miso = tx_byte[pos(0)];
  end
  // Released line shows the inverse, so a stale level never passes as data.
  always @(posedge ss_n) miso = ~miso;
  // Every clock change while selected counts; sampling and driving edges alternate.
  always @(sck) begin
    if (ss_n === 1'h0) begin
      k = k + 1;
      if ((k % 2) != clock_sample_phase) acc[pos((k - 1) / 2)] = mosi;
      else if (k < 16) miso = tx_byte[pos(k / 2)];
      if (k == 16) begin
        rx_byte = acc;
        k = 0;
        if (!clock_sample_phase) miso = tx_byte[pos(0)];
      end
    end
  end
endmodule

// [dv/test_spi_shift_transfer_core.sv]
// Self-checking bench for the serial shift core as master and as slave.
`timescale 1ns/1ps
`include "sstc_params.svh"
module test_spi_shift_transfer_core import sstc_pkg::*; ;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sstc_pins_t pin_i, pin_o, pin_oe;
  logic bench_sck = 1'h0;
  logic bench_mosi = 1'h0;
  logic bench_ss = 1'h1;
  logic m_clock_sample_phase = 1'h0;
  logic m_lsbf = 1'h0;
  logic [7:0] s_tx = 8'h00;
  logic miso_m, sck_w, mosi_w, miso_w, ss_w, sck_q, ss_q;
  logic [7:0] rx_m;
  int n_fail = 0;
  int samples_checked = 0;
  int edges, run, half_seen, ss_rises;
  int cyc = 0;
  // A 100 ns bus clock.
  always #50 aclk = ~aclk;
  // Each wire takes the level of whichever party enables its driver.
  assign sck_w = pin_oe.sck ? pin_o.sck : bench_sck;
  assign mosi_w = pin_oe.mosi ? pin_o.mosi : bench_mosi;
  assign miso_w = pin_oe.miso ? pin_o.miso : miso_m;
  assign ss_w = pin_oe.ss_n ? pin_o.ss_n : bench_ss;
  assign pin_i = {sck_w, mosi_w, miso_w, ss_w};
  sstc_core dut (.*);
  // The far side listens with the phase the core is set to.
  sstc_slave_model peer (
    .sck(sck_w),
    .mosi(mosi_w),
    .ss_n(ss_w),
    .clock_sample_phase(m_clock_sample_phase),
    .lsbf(m_lsbf),
    .tx_byte(s_tx),
    .miso(miso_m),
    .rx_byte(rx_m)
  );
  // Link monitor on the falling edge, where the pins have settled.
  always @(negedge aclk) begin
    cyc = cyc + 1;
    if (sck_w !== sck_q) begin
      edges = edges + 1;
      half_seen = run;
      run = 1;
    end else begin
      run = run + 1;
    end
    if (ss_w === 1'h1 && ss_q === 1'h0) ss_rises = ss_rises + 1;
    sck_q = sck_w;
    ss_q = ss_w;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked = samples_checked + 1;
    if (g !== x) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Handshakes are judged at the falling edge, acted on at the next rise.
  task automatic axw(input logic [3:0] i, input logic [7:0] d,
                     input logic [1:0] x);
    logic a, w, b;
    logic [1:0] r;
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int t = 0; t < 100; t++) begin
      @(negedge aclk);
      a = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b === 1'h1) break;
    end
    chk(r, x);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] m,
                    input logic [7:0] x, input logic [1:0] xr);
    logic a, b;
    logic [31:0] v;
    logic [1:0] r;
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int t = 0; t < 100; t++) begin
      @(negedge aclk);
      a = arready;
      b = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'h0;
      if (b === 1'h1) break;
    end
    chk(v & {24'hffffff, m}, {24'h0, x});
    chk(r, xr);
  endtask
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(`SSTC_IDX_CR1, 8'hff, 8'h00, `SSTC_RESP_OK);
    rd(`SSTC_IDX_CR2, 8'hff, 8'h00, `SSTC_RESP_OK);
    rd(`SSTC_IDX_BR, 8'hff, 8'h00, `SSTC_RESP_OK);
    rd(`SSTC_IDX_SR, 8'hff, 8'h20, `SSTC_RESP_OK);
    axw(`SSTC_IDX_CR2, 8'hff, `SSTC_RESP_OK);
    rd(`SSTC_IDX_CR2, 8'hff, 8'h13, `SSTC_RESP_OK);
    axw(`SSTC_IDX_BR, 8'hff, `SSTC_RESP_OK);
    rd(`SSTC_IDX_BR, 8'hff, 8'h77, `SSTC_RESP_OK);
    axw(`SSTC_IDX_SR, 8'hff, `SSTC_RESP_OK);
    rd(`SSTC_IDX_SR, 8'hff, 8'h20, `SSTC_RESP_OK);
    axw(`SSTC_IDX_RSV4, 8'hff, `SSTC_RESP_OK);
    rd(`SSTC_IDX_RSV4, 8'hff, 8'h00, `SSTC_RESP_OK);
    rd(4'hb, 8'h00, 8'h00, `SSTC_RESP_ERR);
    axw(4'hc, 8'h01, `SSTC_RESP_ERR);
    axw(`SSTC_IDX_CR2, 8'h10, `SSTC_RESP_OK);
    axw(`SSTC_IDX_IEN, 8'h01, `SSTC_RESP_OK);
  endtask
  // Master transfer in mode m: bit2 idle level, bit1 phase, bit0 order.
  task automatic t_xfer(input logic [2:0] m);
    logic [7:0] c1, br, d;
    int half;
    c1 = 8'hd2 | {4'h0, m[2], m[1], 1'h0, m[0]};
    br = (m == 3'h7) ? 8'h22 : 8'h03;
    d = {m, 5'h0d};
    half = (int'(br[6:4]) + 1) << br[2:0];
    s_tx <= ~d;
    m_clock_sample_phase <= m[1];
    m_lsbf <= m[0];
    axw(`SSTC_IDX_CR1, c1, `SSTC_RESP_OK);
    axw(`SSTC_IDX_BR, br, `SSTC_RESP_OK);
    edges = 0;
    axw(`SSTC_IDX_DR, d, `SSTC_RESP_OK);
    for (int t = 0; t < 3000 && irq !== 1'h1; t++) @(posedge aclk);
    chk(irq, 1'h1);
    chk(edges, 16);
    chk(half_seen, half);
    chk(rx_m, d);
    rd(`SSTC_IDX_SR, 8'ha0, 8'ha0, `SSTC_RESP_OK);
    rd(`SSTC_IDX_DR, 8'hff, ~d, `SSTC_RESP_OK);
    axw(`SSTC_IDX_ICLR, 8'h07, `SSTC_RESP_OK);
    chk(irq, 1'h0);
  endtask
  // Two bytes queued back to back; select must lift between them only in phase zero.
  task automatic t_pair(input logic cp);
    m_clock_sample_phase <= cp;
    m_lsbf <= 1'h0;
    s_tx <= 8'h5a;
    axw(`SSTC_IDX_CR1, 8'hd2 | {5'h0, cp, 2'h0}, `SSTC_RESP_OK);
    axw(`SSTC_IDX_BR, 8'h03, `SSTC_RESP_OK);
    edges = 0;
    ss_rises = 0;
    axw(`SSTC_IDX_DR, 8'h3c, `SSTC_RESP_OK);
    axw(`SSTC_IDX_DR, 8'hc6, `SSTC_RESP_OK);
    for (int t = 0; t < 3000 && edges < 32; t++) @(posedge aclk);
    repeat (30) @(posedge aclk);
    chk(edges, 32);
    chk(rx_m, 8'hc6);
    chk(ss_rises, cp ? 1 : 2);
    rd(`SSTC_IDX_SR, 8'h80, 8'h80, `SSTC_RESP_OK);
    rd(`SSTC_IDX_DR, 8'hff, 8'h5a, `SSTC_RESP_OK);
    axw(`SSTC_IDX_ICLR, 8'h07, `SSTC_RESP_OK);
  endtask
  // A rival pulls select low: flag, master bit lost, masked then raised.
  task automatic t_fault();
    axw(`SSTC_IDX_CR1, 8'hd0, `SSTC_RESP_OK);
    bench_ss <= 1'h0;
    repeat (10) @(posedge aclk);
    chk(irq, 1'h0);
    rd(`SSTC_IDX_SR, 8'h10, 8'h10, `SSTC_RESP_OK);
    rd(`SSTC_IDX_CR1, 8'hff, 8'hc0, `SSTC_RESP_OK);
    axw(`SSTC_IDX_IEN, 8'h05, `SSTC_RESP_OK);
    chk(irq, 1'h1);
    axw(`SSTC_IDX_ICLR, 8'h04, `SSTC_RESP_OK);
    chk(irq, 1'h0);
    bench_ss <= 1'h1;
    axw(`SSTC_IDX_IEN, 8'h01, `SSTC_RESP_OK);
  endtask
  // Core as slave: ignores clocks while unselected, then swaps a byte.
  task automatic t_slave();
    logic [7:0] got;
    logic [7:0] s_in;
    s_in = 8'h5c;
    axw(`SSTC_IDX_CR1, 8'h40, `SSTC_RESP_OK);
    axw(`SSTC_IDX_DR, 8'h96, `SSTC_RESP_OK);
    axw(`SSTC_IDX_ICLR, 8'h07, `SSTC_RESP_OK);
    repeat (16) begin
      repeat (4) @(posedge aclk);
      bench_sck <= ~bench_sck;
    end
    repeat (8) @(posedge aclk);
    chk(pin_oe.miso, 1'h0);
    rd(`SSTC_IDX_IST, 8'h01, 8'h00, `SSTC_RESP_OK);
    bench_ss <= 1'h0;
    repeat (8) @(posedge aclk);
    // Data is read just before the falling edge, long after it settled.
    for (int i = 7; i >= 0; i--) begin
      bench_mosi <= s_in[i];
      repeat (4) @(posedge aclk);
      bench_sck <= 1'h1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      got[i] = miso_w;
      @(posedge aclk);
      bench_sck <= 1'h0;
    end
    repeat (10) @(posedge aclk);
    bench_ss <= 1'h1;
    chk(got, 8'h96);
    rd(`SSTC_IDX_SR, 8'h80, 8'h80, `SSTC_RESP_OK);
    rd(`SSTC_IDX_DR, 8'hff, 8'h5c, `SSTC_RESP_OK);
  endtask
  // Reset for two cycles, let the pin filters settle, then run the cases.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (5) @(posedge aclk);
    t_regs();
    for (int m = 0; m < 8; m++) t_xfer(m[2:0]);
    t_pair(1'h0);
    t_pair(1'h1);
    t_fault();
    t_slave();
    results();
  end
endmodule
